// file: include/bbc_pkg.sv
// package for the channel 0 configuration register bank
// assumes a simple byte-wide register port from the serial interface logic
package bbc_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CHIP_IDENTITY = 8'h06;
  localparam logic [7:0] ADDR_SWITCH_DRIVE_TRIM = 8'h07;
  localparam logic [7:0] ADDR_CH0_VOLTAGE_TARGET = 8'h08;
  localparam logic [7:0] ADDR_CH0_ENABLE_CONFIG = 8'h09;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int DRIVE_LSB = 0;
  localparam int DRIVE_WIDTH = 2;
  localparam int ENSEL_LSB = 0;
  localparam int ENSEL_WIDTH = 3;
  localparam int DISCH_BIT = 3;
  localparam int CFG_HI_LSB = 4;
  localparam logic [7:0] RESET_DRIVE_TRIM = 8'h00;
  localparam logic [7:0] RESET_VOLTAGE_TARGET = 8'h00;
  localparam logic [7:0] RESET_ENABLE_CONFIG = 8'h00;
  // highest code that is not reserved (4.000 V)
  localparam logic [7:0] VOLTAGE_CODE_MAX = 8'h8c;
  // arbitrary neutral default for the identity straps
  localparam logic [7:0] CHIP_IDENTITY_DEFAULT = 8'h00;
  // target in millivolts: base plus step times code
  localparam int TARGET_BASE_MV = 500;
  localparam int TARGET_STEP_MV = 25;

  // ----------------------------------------------------------------
  // enable selector codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ENSEL_SLOT0 = 3'h0,
    ENSEL_SLOT1 = 3'h1,
    ENSEL_SLOT2 = 3'h2,
    ENSEL_SLOT3 = 3'h3,
    ENSEL_OFF_A = 3'h4,
    ENSEL_OFF_B = 3'h5,
    ENSEL_ON_A = 3'h6,
    ENSEL_ON_B = 3'h7
  } bbc_ensel_e;

  // register port request carrier
  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bbc_req_s;

  // channel 0 control carrier toward the power stage
  typedef struct packed {
    logic [1:0] driveStrength;
    logic [7:0] targetCode;
    logic [1:0] slot;
    logic forceOn;
    logic forceOff;
    logic dischargeEnable;
  } bbc_ctrl_s;

endpackage

// file: rtl/bbc_config_regs.sv
// register bank: chip identity, switch drive trim, channel 0 config
// assumes the serial interface delivers one-cycle read/write strobes on mclk
`timescale 1ns/1ps

// Summary of operation
// - read-only 8-bit identity register follows the factory straps; writes ignored
// - 2-bit drive strength field, shared by all channels, sets switch edge speed
// - upper six bits of drive trim are reserved and affect nothing
// - target voltage equals 0.5 V plus 25 mV times the code
// - enable selector codes 0 to 3 assign a sequencer slot
// - codes 4,5 force the channel off; codes 6,7 force it on
// - discharge bit switches the resistor on while the channel is disabled
module bbc_config_regs (
  input wire logic mclk,
  input wire logic rst,
  input wire bbc_pkg::bbc_req_s req,
  input wire logic [7:0] chipIdentityCode,
  input wire logic [3:0] slotActive,
  output logic [7:0] rdata,
  output logic rvalid,
  output bbc_pkg::bbc_ctrl_s ctrl,
  output logic channelEnable,
  output logic dischargeOn,
  output logic [12:0] targetMv,
  output logic codeReserved
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] driveTrim;
  logic [7:0] voltageTarget;
  logic [7:0] enableConfig;
  logic [7:0] identity;
  logic [7:0] next_rdata;
  logic next_enable;
  bbc_pkg::bbc_ensel_e enSel;

  // identity straps captured every cycle; no write path exists
  always_ff @(posedge mclk) begin
    if (rst) begin
      identity <= bbc_pkg::CHIP_IDENTITY_DEFAULT;
    end else begin
      identity <= chipIdentityCode;
    end
  end

  // drive trim register, reserved bits kept but unused
  always_ff @(posedge mclk) begin
    if (rst) begin
      driveTrim <= bbc_pkg::RESET_DRIVE_TRIM;
    end else if (req.write && req.addr == bbc_pkg::ADDR_SWITCH_DRIVE_TRIM) begin
      driveTrim <= req.wdata;
    end
  end

  // channel 0 target code register
  always_ff @(posedge mclk) begin
    if (rst) begin
      voltageTarget <= bbc_pkg::RESET_VOLTAGE_TARGET;
    end else if (req.write && req.addr == bbc_pkg::ADDR_CH0_VOLTAGE_TARGET) begin
      voltageTarget <= req.wdata;
    end
  end

  // channel 0 enable and discharge register
  always_ff @(posedge mclk) begin
    if (rst) begin
      enableConfig <= bbc_pkg::RESET_ENABLE_CONFIG;
    end else if (req.write && req.addr == bbc_pkg::ADDR_CH0_ENABLE_CONFIG) begin
      enableConfig <= req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // read mux, unmapped offsets return zero
  always_comb begin
    unique case (req.addr)
      bbc_pkg::ADDR_CHIP_IDENTITY: next_rdata = identity;
      bbc_pkg::ADDR_SWITCH_DRIVE_TRIM: next_rdata = driveTrim;
      bbc_pkg::ADDR_CH0_VOLTAGE_TARGET: next_rdata = voltageTarget;
      bbc_pkg::ADDR_CH0_ENABLE_CONFIG: next_rdata = enableConfig;
      default: next_rdata = 8'h00;
    endcase
  end

  // registered read data, valid one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.read;
      if (req.read) begin
        rdata <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // channel control decode
  // ----------------------------------------------------------------
  assign enSel = bbc_pkg::bbc_ensel_e'(enableConfig[bbc_pkg::ENSEL_LSB +: bbc_pkg::ENSEL_WIDTH]);

  // selector decode: slot, forced off or forced on
  always_comb begin
    unique case (enSel)
      bbc_pkg::ENSEL_SLOT0,
      bbc_pkg::ENSEL_SLOT1,
      bbc_pkg::ENSEL_SLOT2,
      bbc_pkg::ENSEL_SLOT3: next_enable = slotActive[enSel[1:0]];
      bbc_pkg::ENSEL_OFF_A,
      bbc_pkg::ENSEL_OFF_B: next_enable = 1'b0;
      bbc_pkg::ENSEL_ON_A,
      bbc_pkg::ENSEL_ON_B: next_enable = 1'b1;
    endcase
  end

  // registered controls toward the power stage
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl <= '0;
      channelEnable <= 1'b0;
      dischargeOn <= 1'b0;
    end else begin
      ctrl.driveStrength <= driveTrim[bbc_pkg::DRIVE_LSB +: bbc_pkg::DRIVE_WIDTH];
      ctrl.targetCode <= voltageTarget;
      ctrl.slot <= enSel[1:0];
      ctrl.forceOn <= enSel[2] & enSel[1];
      ctrl.forceOff <= enSel[2] & ~enSel[1];
      ctrl.dischargeEnable <= enableConfig[bbc_pkg::DISCH_BIT];
      channelEnable <= next_enable;
      dischargeOn <= enableConfig[bbc_pkg::DISCH_BIT] & ~next_enable;
    end
  end

  // millivolt target and reserved-code flag
  bbc_target_decode u_decode (
    .code(voltageTarget),
    .targetMv(targetMv),
    .codeReserved(codeReserved)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_cfg_write(logic [7:0] a);
    req.write && req.addr == a;
  endsequence

  property p_id_follow;
    @(posedge mclk) disable iff (rst)
      ##1 1'b1 |-> identity == $past(chipIdentityCode);
  endproperty
  a_id_follow: assert property (p_id_follow) else $error("identity lost");

  property p_drive;
    @(posedge mclk) disable iff (rst)
      s_cfg_write(bbc_pkg::ADDR_SWITCH_DRIVE_TRIM) ##1 !req.write |=>
        ctrl.driveStrength == $past(req.wdata[1:0], 2);
  endproperty
  a_drive: assert property (p_drive) else $error("drive not applied");

  property p_reserved;
    @(posedge mclk) disable iff (rst)
      s_cfg_write(bbc_pkg::ADDR_SWITCH_DRIVE_TRIM) ##0 (req.wdata[1:0] == driveTrim[1:0]) |=>
        ##1 $stable(ctrl.driveStrength);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits act");

  property p_target;
    @(posedge mclk) disable iff (rst)
      1'b1 |-> targetMv == 13'(500 + 25 * int'(voltageTarget));
  endproperty
  a_target: assert property (p_target) else $error("target mismatch");

  property p_slot;
    @(posedge mclk) disable iff (rst)
      !enSel[2] |=> channelEnable == $past(slotActive[enSel[1:0]]);
  endproperty
  a_slot: assert property (p_slot) else $error("slot enable wrong");

  property p_force;
    @(posedge mclk) disable iff (rst)
      enSel[2] |=> channelEnable == $past(enSel[1]);
  endproperty
  a_force: assert property (p_force) else $error("force wrong");

  property p_discharge;
    @(posedge mclk) disable iff (rst)
      ##1 1'b1 |-> dischargeOn == (ctrl.dischargeEnable && !channelEnable);
  endproperty
  a_discharge: assert property (p_discharge) else $error("discharge wrong");

  property p_off_discharge;
    @(posedge mclk) disable iff (rst)
      enSel[2] && !enSel[1] |=> dischargeOn == $past(enableConfig[bbc_pkg::DISCH_BIT]);
  endproperty
  a_off_discharge: assert property (p_off_discharge) else $error("off discharge");

  property p_reset;
    @(posedge mclk) rst |=> driveTrim == 8'h00 && voltageTarget == 8'h00 && enableConfig == 8'h00;
  endproperty
  a_reset: assert property (p_reset) else $error("reset value wrong");

endmodule

// file: rtl/bbc_target_decode.sv
// decoder from target voltage code to millivolts and reserved flag
// assumes a purely combinational consumer
`timescale 1ns/1ps

module bbc_target_decode (
  input wire logic [7:0] code,
  output logic [12:0] targetMv,
  output logic codeReserved
);

  // linear map: base plus step per code
  always_comb begin
    targetMv = 13'(bbc_pkg::TARGET_BASE_MV) + 13'(bbc_pkg::TARGET_STEP_MV) * {5'h00, code};
    codeReserved = code > bbc_pkg::VOLTAGE_CODE_MAX;
  end

endmodule

// file: test/tb_top.sv
// testbench for the channel 0 configuration register bank
// assumes bbc_pkg is compiled first and the bank speaks one-cycle strobes
`timescale 1ns/1ps

module tb_top;
  // ----------------------------------------------------------------
  // design connections
  // ----------------------------------------------------------------
  logic mclk;
  logic rst;
  bbc_pkg::bbc_req_s req;
  logic [7:0] chipIdentityCode;
  logic [3:0] slotActive;
  logic [7:0] rdata;
  logic rvalid;
  bbc_pkg::bbc_ctrl_s ctrl;
  logic channelEnable;
  logic dischargeOn;
  logic [12:0] targetMv;
  logic codeReserved;
  int errorCnt;
  int testsRun;
  logic [7:0] v;
  logic on;
  logic [7:0] codes [5] = '{8'h00, 8'h01, 8'h8c, 8'h8d, 8'hff};

  bbc_config_regs bbc_config_regs_i (
    .mclk(mclk),
    .rst(rst),
    .req(req),
    .chipIdentityCode(chipIdentityCode),
    .slotActive(slotActive),
    .rdata(rdata),
    .rvalid(rvalid),
    .ctrl(ctrl),
    .channelEnable(channelEnable),
    .dischargeOn(dischargeOn),
    .targetMv(targetMv),
    .codeReserved(codeReserved)
  );

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  // compare one result and count it
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    testsRun++;
    if (got !== exp) begin
      errorCnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    req.write = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge mclk);
    req.write = 1'b0;
  endtask

  // one-cycle read strobe, answer sampled one cycle later
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    req.read = 1'b1;
    req.addr = a;
    @(negedge mclk);
    req.read = 1'b0;
    chk(rvalid, 1'b1);
    chk(rdata, exp);
  endtask

  // let the two-cycle control update land
  task automatic settle();
    repeat (2) @(negedge mclk);
  endtask

  // verdict and end of run
  task automatic endOfTest();
    $display("counts: %0d compared, %0d mismatched", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  // main sequence
  initial begin
    rst = 1'b1;
    req = '0;
    chipIdentityCode = 8'h5a;
    slotActive = 4'h5;
    errorCnt = 0;
    testsRun = 0;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    rd(8'h07, 8'h00);
    rd(8'h08, 8'h00);
    rd(8'h09, 8'h00);
    chk(targetMv, 16'h01f4);
    chk(ctrl, 16'h0000);
    $display("test reset done");
    rd(8'h06, 8'h5a);
    wr(8'h06, 8'ha5);
    rd(8'h06, 8'h5a);
    rd(8'h0a, 8'h00);
    $display("test identity done");
    for (int d = 0; d < 4; d++) begin
      wr(8'h07, {6'h2a, d[1:0]});
      settle();
      chk(ctrl.driveStrength, d[1:0]);
      chk(ctrl.targetCode, 8'h00);
      rd(8'h07, {6'h2a, d[1:0]});
    end
    wr(8'h07, 8'h57);
    settle();
    chk(ctrl.driveStrength, 2'h3);
    rd(8'h07, 8'h57);
    $display("test drive done");
    foreach (codes[i]) begin
      wr(8'h08, codes[i]);
      settle();
      chk(targetMv, 16'(500 + 25 * codes[i]));
      chk(codeReserved, codes[i] > 8'h8c);
      chk(ctrl.targetCode, codes[i]);
    end
    $display("test target done");
    for (int e = 0; e < 16; e++) begin
      v = {4'h0, e[3:0]};
      on = e[2] ? e[1] : slotActive[e[1:0]];
      wr(8'h09, v);
      settle();
      chk(channelEnable, on);
      chk(ctrl.forceOn, e[2:1] == 2'b11);
      chk(ctrl.forceOff, e[2:1] == 2'b10);
      if (!e[2]) chk(ctrl.slot, e[1:0]);
      chk(dischargeOn, e[3] & !on);
      rd(8'h09, v);
    end
    wr(8'h09, 8'h09);
    settle();
    chk(channelEnable, 1'b0);
    chk(dischargeOn, 1'b1);
    slotActive = 4'h2;
    settle();
    chk(channelEnable, 1'b1);
    chk(dischargeOn, 1'b0);
    slotActive = 4'h5;
    // bias return to low power lives outside this bank
    $display("test enable done");
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    rd(8'h07, 8'h00);
    rd(8'h08, 8'h00);
    rd(8'h09, 8'h00);
    chk(ctrl, 16'h0000);
    rd(8'h06, 8'h5a);
    $display("test second reset done");
    endOfTest();
  end

  // watchdog against a hang
  initial begin
    #50us;
    errorCnt++;
    endOfTest();
  end
endmodule
